// File: src/uotg_cfg.svh
`ifndef UOTG_CFG_SVH
`define UOTG_CFG_SVH
// Overview of operation
// - one system clock times every USB interval this block measures
// - host mode is an embedded host, no standard controller register model
// - handshake progress is tracked by hardware, no software per transaction
// - packet data moves by the module's own DMA engine, gated here
// - event flags set by hardware, cleared by writing one, reset zero
// - bit 7 sets on any change of the ID pin
// - bit 6 sets each time the 1 ms timer expires
// - bit 5 sets when line state holds 1 ms at a new value
// - bit 4 sets when D+, D-, ID or VBUS activity wakes the module
// - bit 3 sets when VBUS falls below the session end level
// - bit 2 sets on any change of the session end comparator
// - bit 0 sets on session valid change; bit 1 unimplemented
// - bits 31 to 8 of both registers read as zero
// - control bit 7 shows live J state, read only
// - control bit 6 shows live single ended zero, read only
// - device mode: bit 5 disables packet processing, set on SETUP
// - host mode: bit 5 reads token busy; software polls before next token
// - host mode: bit 4 drives USB reset while set
// - bit 3 enables host; any toggle resets host control logic
// - host mode: clearing resume appends a low speed end of packet

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define UOTG_OFS_EVENT 8'h00
`define UOTG_OFS_CTRL 8'h04
`define UOTG_EVENT_RST 8'h00
`define UOTG_CTRL_RST 6'h00
`define UOTG_EVENT_IMPL 8'hFD

// event flag bit positions
`define UOTG_EV_ID 7
`define UOTG_EV_MS 6
`define UOTG_EV_LINE 5
`define UOTG_EV_ACT 4
`define UOTG_EV_SDROP 3
`define UOTG_EV_BVBUS 2
`define UOTG_EV_AVBUS 0

// control bit positions
`define UOTG_CT_J 7
`define UOTG_CT_SE0 6
`define UOTG_CT_PKT 5
`define UOTG_CT_RST 4
`define UOTG_CT_HOST 3
`define UOTG_CT_RES 2
`define UOTG_CT_PPB 1
`define UOTG_CT_EN 0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define UOTG_CLK_MHZ 20
`define UOTG_MS_US 1000
`define UOTG_MS_CYC (`UOTG_MS_US * `UOTG_CLK_MHZ)
`define UOTG_LSEOP_NS 1333
`define UOTG_LSEOP_CYC ((`UOTG_LSEOP_NS * `UOTG_CLK_MHZ + 999) / 1000)
`endif

// File: src/uotg_pkg.sv
package uotg_pkg;
   // bus side levels seen by the block, already in the clk_sys domain
   typedef struct packed {
      logic dp;
      logic dm;
      logic id;
      logic vbus_above_end;
      logic vbus_valid;
   } uotg_line_s;

   typedef enum logic [1:0] {
      UOTG_RS_IDLE = 2'b00,
      UOTG_RS_DRIVE = 2'b01,
      UOTG_RS_EOP = 2'b11
   } uotg_res_e;
endpackage : uotg_pkg

// File: src/uotg_stable.sv
`timescale 1ns/1ps
module uotg_stable #(
   parameter int W = 2,
   parameter int HOLD_CYC = 20000
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] val,
   output logic stable_new
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0] HOLD = CW'(HOLD_CYC);

   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [W-1:0] cur_r, cur_nxt;
   logic [W-1:0] stab_r, stab_nxt;
   logic fire_r, fire_nxt;

   // counter saturates so a long steady state fires only once
   always_comb begin
      cnt_nxt = cnt_r;
      cur_nxt = cur_r;
      stab_nxt = stab_r;
      fire_nxt = 1'b0;
      if (val != cur_r) begin
         cnt_nxt = '0;
         cur_nxt = val;
      end else if (cnt_r < HOLD - 1'b1) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (cnt_r == HOLD - 1'b1) begin
         cnt_nxt = HOLD;
         stab_nxt = cur_r;
         fire_nxt = (cur_r != stab_r);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_r <= '0;
         cur_r <= '0;
         stab_r <= '0;
         fire_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         cur_r <= cur_nxt;
         stab_r <= stab_nxt;
         fire_r <= fire_nxt;
      end
   end

   assign stable_new = fire_r;
endmodule : uotg_stable

// File: src/uotg_ctrl.sv
`timescale 1ns/1ps
`include "uotg_cfg.svh"
module uotg_ctrl #(
   parameter int MS_CYC = `UOTG_MS_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire uotg_pkg::uotg_line_s line,
   input wire logic setup_rx,
   input wire logic tok_issue,
   input wire logic tok_done,
   output logic pkt_proc_disable,
   output logic token_in_progress,
   output logic bus_reset_drive,
   output logic host_capability_enable,
   output logic host_logic_reset,
   output logic resume_drive,
   output logic ls_eop_drive,
   output logic module_enable,
   output logic frame_marker_enable,
   output logic ping_pong_pointer_reset
);
   import uotg_pkg::*;

   localparam int MW = $clog2(MS_CYC + 1);
   localparam logic [MW-1:0] MS_LAST = MW'(MS_CYC - 1);
   localparam int EW = $clog2(`UOTG_LSEOP_CYC + 1);
   localparam logic [EW-1:0] EOP_LAST = EW'(`UOTG_LSEOP_CYC - 1);

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic ap_wr_r, ap_wr_nxt;
   logic [7:0] ap_ofs_r, ap_ofs_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic take;
   logic wr_ev, wr_ct;
   logic [7:0] ev_r, ev_nxt, ev_set, ev_clr;
   logic [5:0] ctl_r, ctl_nxt;
   logic live_j, live_se0;
   logic is_host;
   logic tok_r, tok_nxt;
   logic hrst_r, hrst_nxt;
   logic brst_r, brst_nxt;

   // zero wait states: the map is flip-flops only, nothing to stall for
   assign take = hsel && htrans[1] && hready;
   assign wr_ev = ap_wr_r && (ap_ofs_r == `UOTG_OFS_EVENT);
   assign wr_ct = ap_wr_r && (ap_ofs_r == `UOTG_OFS_CTRL);

   always_comb begin
      ap_wr_nxt = 1'b0;
      ap_ofs_nxt = ap_ofs_r;
      rdata_nxt = rdata_r;
      if (take) begin
         // writes outside the decoded page are dropped
         ap_wr_nxt = hwrite && (haddr[31:8] == 24'h00_0000);
         ap_ofs_nxt = haddr[7:0];
         rdata_nxt = 32'h0000_0000;
         if (!hwrite && haddr[31:8] == 24'h00_0000) begin
            // next values so a write just before is seen
            case (haddr[7:0])
               `UOTG_OFS_EVENT: rdata_nxt[7:0] = ev_nxt;
               `UOTG_OFS_CTRL: begin
                  rdata_nxt[`UOTG_CT_J] = live_j;
                  rdata_nxt[`UOTG_CT_SE0] = live_se0;
                  rdata_nxt[5:0] = ctl_nxt;
                  // token busy replaces bit 5 in host mode
                  if (ctl_nxt[`UOTG_CT_HOST])
                     rdata_nxt[`UOTG_CT_PKT] = tok_nxt;
               end
               // nothing else is mapped; no host controller model
               default: rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ap_wr_r <= 1'b0;
         ap_ofs_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         ap_wr_r <= ap_wr_nxt;
         ap_ofs_r <= ap_ofs_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;

   // ---------------------------------------------------------------
   // line watch and 1 ms timer
   // ---------------------------------------------------------------
   uotg_line_s prev_r;
   logic prev_ok_r;
   logic [MW-1:0] ms_cnt_r, ms_cnt_nxt;
   logic ms_tick;
   logic line_new;
   logic changed;

   // full speed polarity: J is D+ high, D- low
   assign live_j = line.dp && !line.dm;
   assign live_se0 = !line.dp && !line.dm;
   assign is_host = ctl_r[`UOTG_CT_HOST];
   assign changed = prev_ok_r && (line != prev_r);

   // every interval is counted on clk_sys alone
   assign ms_tick = (ms_cnt_r == MS_LAST);
   always_comb begin
      ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prev_r <= '0;
         prev_ok_r <= 1'b0;
         ms_cnt_r <= '0;
      end else begin
         prev_r <= line;
         prev_ok_r <= 1'b1;
         ms_cnt_r <= ms_cnt_nxt;
      end
   end

   uotg_stable #(
      .W(2),
      .HOLD_CYC(MS_CYC)
   ) u_stable (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .val({line.dp, line.dm}),
      .stable_new(line_new)
   );

   // ---------------------------------------------------------------
   // event flags
   // ---------------------------------------------------------------
   always_comb begin
      ev_set = 8'h00;
      ev_set[`UOTG_EV_ID] = prev_ok_r && (line.id != prev_r.id);
      ev_set[`UOTG_EV_MS] = ms_tick;
      ev_set[`UOTG_EV_LINE] = line_new;
      // a module left disabled is asleep; any line move wakes it
      ev_set[`UOTG_EV_ACT] = changed && !ctl_r[`UOTG_CT_EN];
      ev_set[`UOTG_EV_SDROP] = prev_ok_r && prev_r.vbus_above_end
         && !line.vbus_above_end;
      ev_set[`UOTG_EV_BVBUS] = prev_ok_r
         && (line.vbus_above_end != prev_r.vbus_above_end);
      ev_set[`UOTG_EV_AVBUS] = prev_ok_r
         && (line.vbus_valid != prev_r.vbus_valid);
      ev_clr = wr_ev ? hwdata[7:0] : 8'h00;
      // set applied after clear, zeros leave the flag alone
      ev_nxt = ((ev_r & ~ev_clr) | ev_set) & `UOTG_EVENT_IMPL;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ev_r <= `UOTG_EVENT_RST;
      end else begin
         ev_r <= ev_nxt;
      end
   end

   // ---------------------------------------------------------------
   // control, token and host reset
   // ---------------------------------------------------------------
   always_comb begin
      ctl_nxt = ctl_r;
      if (wr_ct)
         ctl_nxt = hwdata[5:0];
      // a SETUP seen in device mode halts packet processing
      if (setup_rx && !is_host)
         ctl_nxt[`UOTG_CT_PKT] = 1'b1;
      // toggle of host enable pulses host reset
      hrst_nxt = ctl_nxt[`UOTG_CT_HOST] != ctl_r[`UOTG_CT_HOST];
      // busy from issue to hardware completion
      tok_nxt = tok_r;
      if (tok_done)
         tok_nxt = 1'b0;
      if (tok_issue && is_host)
         tok_nxt = 1'b1;
      if (hrst_nxt || !ctl_nxt[`UOTG_CT_HOST])
         tok_nxt = 1'b0;
      brst_nxt = ctl_nxt[`UOTG_CT_RST] && ctl_nxt[`UOTG_CT_HOST];
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctl_r <= `UOTG_CTRL_RST;
         tok_r <= 1'b0;
         hrst_r <= 1'b0;
         brst_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         tok_r <= tok_nxt;
         hrst_r <= hrst_nxt;
         brst_r <= brst_nxt;
      end
   end

   // the DMA engine only moves data while this stays low
   assign pkt_proc_disable = ctl_r[`UOTG_CT_PKT] && !is_host;
   assign token_in_progress = tok_r;
   assign bus_reset_drive = brst_r;
   assign host_capability_enable = is_host;
   assign host_logic_reset = hrst_r;
   assign module_enable = ctl_r[`UOTG_CT_EN] && !is_host;
   assign frame_marker_enable = ctl_r[`UOTG_CT_EN] && is_host;
   assign ping_pong_pointer_reset = ctl_r[`UOTG_CT_PPB];

   // ---------------------------------------------------------------
   // resume signalling
   // ---------------------------------------------------------------
   uotg_res_e rs_r, rs_nxt;
   logic [EW-1:0] eop_r, eop_nxt;

   // length of resume is software's to time; only the tail is ours
   always_comb begin
      rs_nxt = rs_r;
      eop_nxt = eop_r;
      case (rs_r)
         UOTG_RS_IDLE: begin
            if (ctl_r[`UOTG_CT_RES])
               rs_nxt = UOTG_RS_DRIVE;
         end
         UOTG_RS_DRIVE: begin
            if (!ctl_r[`UOTG_CT_RES]) begin
               eop_nxt = '0;
               rs_nxt = is_host ? UOTG_RS_EOP : UOTG_RS_IDLE;
            end
         end
         UOTG_RS_EOP: begin
            eop_nxt = eop_r + 1'b1;
            if (eop_r == EOP_LAST)
               rs_nxt = UOTG_RS_IDLE;
         end
         default: rs_nxt = UOTG_RS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rs_r <= UOTG_RS_IDLE;
         eop_r <= '0;
      end else begin
         rs_r <= rs_nxt;
         eop_r <= eop_nxt;
      end
   end

   assign resume_drive = (rs_r == UOTG_RS_DRIVE);
   assign ls_eop_drive = (rs_r == UOTG_RS_EOP);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence s_clear_ms;
      wr_ev && hwdata[`UOTG_EV_MS];
   endsequence

   sequence s_res_off;
      resume_drive && !ctl_r[`UOTG_CT_RES] && is_host;
   endsequence

   a_set_beats_clear: assert property (
      s_clear_ms and ms_tick |=> ev_r[`UOTG_EV_MS])
      else $error("hardware set lost to clear");

   a_w1c_clears: assert property (
      wr_ev && hwdata[`UOTG_EV_ID] && !ev_set[`UOTG_EV_ID]
      |=> !ev_r[`UOTG_EV_ID])
      else $error("write one did not clear flag");

   a_zero_keeps: assert property (
      wr_ev && !hwdata[`UOTG_EV_ACT] && ev_r[`UOTG_EV_ACT]
      |=> ev_r[`UOTG_EV_ACT])
      else $error("write zero changed flag");

   a_id_flag: assert property (
      prev_ok_r && $changed(line.id) |=> ev_r[`UOTG_EV_ID])
      else $error("id change not flagged");

   a_sess_drop: assert property (
      prev_ok_r && $fell(line.vbus_above_end)
      |=> ev_r[`UOTG_EV_SDROP] && ev_r[`UOTG_EV_BVBUS])
      else $error("vbus drop not flagged");

   a_upper_zero: assert property (
      hrdata[31:8] == 24'h00_0000 && !ev_r[1])
      else $error("unimplemented bits nonzero");

   a_bus_reset: assert property (
      is_host && ctl_r[`UOTG_CT_RST] |-> bus_reset_drive)
      else $error("host reset not driven");

   a_host_toggle: assert property (
      $changed(is_host) |-> host_logic_reset && !token_in_progress)
      else $error("host toggle did not reset host logic");

   a_eop_tail: assert property (
      s_res_off |=> ls_eop_drive [*2] ##25 ls_eop_drive ##1 !ls_eop_drive)
      else $error("low speed eop not appended");

   a_setup_halt: assert property (
      setup_rx && !is_host |=> pkt_proc_disable)
      else $error("setup did not disable packets");

   a_tok_busy: assert property (
      tok_issue && is_host && !tok_done && !host_logic_reset
      && !wr_ct |=> token_in_progress)
      else $error("token busy not shown");

   a_ms_flag: assert property (
      ms_tick |=> ev_r[`UOTG_EV_MS])
      else $error("timer expiry not flagged");

   a_line_flag: assert property (
      line_new |=> ev_r[`UOTG_EV_LINE])
      else $error("stable line change not flagged");

   a_live_read: assert property (
      take && !hwrite && haddr[31:8] == 24'h00_0000
      && haddr[7:0] == `UOTG_OFS_CTRL
      |=> hrdata[`UOTG_CT_J] == $past(live_j)
      && hrdata[`UOTG_CT_SE0] == $past(live_se0))
      else $error("live line bits not reported");
endmodule : uotg_ctrl

// File: verification/uotg_far_end.sv
`timescale 1ns/1ps
module uotg_far_end (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire uotg_pkg::uotg_line_s want,
   input wire logic bus_reset_drive,
   input wire logic resume_drive,
   output uotg_pkg::uotg_line_s line
);
   import uotg_pkg::*;

   // ---------------------------------------------------------------
   // bus levels seen by the block
   // ---------------------------------------------------------------
   uotg_line_s line_r;
   uotg_line_s line_nxt;

   // our bus reset and resume signalling override what the peer would show
   always_comb begin
      line_nxt = want;
      if (bus_reset_drive) begin
         line_nxt.dp = 1'b0;
         line_nxt.dm = 1'b0;
      end else if (resume_drive) begin
         line_nxt.dp = 1'b0;
         line_nxt.dm = 1'b1;
      end
   end

   // one register stage stands in for the receiver path delay
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         line_r <= want;
      end else begin
         line_r <= line_nxt;
      end
   end

   assign line = line_r;
endmodule : uotg_far_end

// File: verification/test_usb_otg_status_control.sv
`timescale 1ns/1ps
`include "uotg_cfg.svh"
module test_usb_otg_status_control;
   import uotg_pkg::*;

   // ---------------------------------------------------------------
   // stimulus and observation
   // ---------------------------------------------------------------
   localparam int MS = 40;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic [2:0] sie = 3'b000;
   uotg_line_s want = 5'h07;
   uotg_line_s line;
   logic pkt_dis, tok_busy, rst_drv, host_en, host_rst, res_drv, eop_drv;
   int err_count = 0;
   int samples_checked = 0;
   int hlr_cnt = 0;
   int eop_cnt = 0;
   logic [31:0] q;

   always #25 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      if (host_rst === 1'b1) hlr_cnt++;
      if (eop_drv === 1'b1) eop_cnt++;
   end

   uotg_ctrl #(.MS_CYC(MS)) dut_u (
      .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(),
      .line(line), .setup_rx(sie[2]), .tok_issue(sie[1]),
      .tok_done(sie[0]), .pkt_proc_disable(pkt_dis),
      .token_in_progress(tok_busy), .bus_reset_drive(rst_drv),
      .host_capability_enable(host_en), .host_logic_reset(host_rst),
      .resume_drive(res_drv), .ls_eop_drive(eop_drv), .module_enable(),
      .frame_marker_enable(), .ping_pong_pointer_reset()
   );

   uotg_far_end far_u (
      .clk_sys(clk_sys), .rstn(rstn), .want(want),
      .bus_reset_drive(rst_drv), .resume_drive(res_drv), .line(line)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic final_report;
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // single word transfer; the bench timeout bounds a stuck slave
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : settle

   task automatic pulse(input logic [2:0] p);
      @(posedge clk_sys);
      sie <= p;
      @(posedge clk_sys);
      sie <= 3'b000;
      settle;
   endtask : pulse

   task automatic set_line(input uotg_line_s v);
      @(posedge clk_sys);
      want <= v;
      repeat (4) @(posedge clk_sys);
   endtask : set_line

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd(`UOTG_OFS_EVENT);
      check(q, 32'h0);
      rd(`UOTG_OFS_CTRL);
      check(q, 32'h40);
   endtask : t_reset

   task automatic t_id;
      uotg_line_s v;
      v = want;
      wr(`UOTG_OFS_EVENT, 32'hFF);
      v.id = ~v.id;
      set_line(v);
      rd(`UOTG_OFS_EVENT);
      check(q[7], 1'b1);
      check(q[4], 1'b1);
      check(q[1], 1'b0);
      check(q[31:8], 32'h0);
      wr(`UOTG_OFS_EVENT, 32'h7F);
      rd(`UOTG_OFS_EVENT);
      check(q[7], 1'b1);
      wr(`UOTG_OFS_EVENT, 32'h80);
      rd(`UOTG_OFS_EVENT);
      check(q[7], 1'b0);
      // an enabled module is awake, so line changes are not wake-ups
      wr(`UOTG_OFS_CTRL, 32'h01);
      wr(`UOTG_OFS_EVENT, 32'hFF);
      v.id = ~v.id;
      set_line(v);
      rd(`UOTG_OFS_EVENT);
      check(q[7], 1'b1);
      check(q[4], 1'b0);
      wr(`UOTG_OFS_CTRL, 32'h00);
   endtask : t_id

   task automatic t_vbus;
      uotg_line_s v;
      v = want;
      wr(`UOTG_OFS_EVENT, 32'hFF);
      v.vbus_above_end = 1'b0;
      set_line(v);
      rd(`UOTG_OFS_EVENT);
      check(q[3], 1'b1);
      check(q[2], 1'b1);
      wr(`UOTG_OFS_EVENT, 32'hFF);
      v.vbus_above_end = 1'b1;
      set_line(v);
      rd(`UOTG_OFS_EVENT);
      check(q[3], 1'b0);
      check(q[2], 1'b1);
      wr(`UOTG_OFS_EVENT, 32'hFF);
      v.vbus_valid = 1'b0;
      set_line(v);
      rd(`UOTG_OFS_EVENT);
      check(q[0], 1'b1);
      check(q[2], 1'b0);
   endtask : t_vbus

   task automatic t_timer;
      wr(`UOTG_OFS_EVENT, 32'h40);
      repeat (MS + 1) @(posedge clk_sys);
      rd(`UOTG_OFS_EVENT);
      check(q[6], 1'b1);
   endtask : t_timer

   task automatic t_line;
      uotg_line_s v;
      v = want;
      wr(`UOTG_OFS_EVENT, 32'hFF);
      v.dp = 1'b1;
      set_line(v);
      repeat (MS + 2) @(posedge clk_sys);
      rd(`UOTG_OFS_EVENT);
      check(q[5], 1'b1);
      rd(`UOTG_OFS_CTRL);
      check(q[7], 1'b1);
      check(q[6], 1'b0);
      wr(`UOTG_OFS_EVENT, 32'h20);
      repeat (MS + 2) @(posedge clk_sys);
      rd(`UOTG_OFS_EVENT);
      check(q[5], 1'b0);
   endtask : t_line

   task automatic t_setup;
      pulse(3'b100);
      check(pkt_dis, 1'b1);
      rd(`UOTG_OFS_CTRL);
      check(q[5], 1'b1);
      wr(`UOTG_OFS_CTRL, 32'h00);
      settle;
      check(pkt_dis, 1'b0);
   endtask : t_setup

   task automatic t_host;
      int c;
      c = hlr_cnt;
      wr(`UOTG_OFS_CTRL, 32'h08);
      settle;
      check(host_en, 1'b1);
      check(hlr_cnt - c, 32'h1);
      wr(`UOTG_OFS_CTRL, 32'h18);
      settle;
      check(rst_drv, 1'b1);
      rd(`UOTG_OFS_CTRL);
      check(q[6], 1'b1);
      check(q[4], 1'b1);
      wr(`UOTG_OFS_CTRL, 32'h08);
      settle;
      check(rst_drv, 1'b0);
      pulse(3'b010);
      check(tok_busy, 1'b1);
      rd(`UOTG_OFS_CTRL);
      check(q[5], 1'b1);
      pulse(3'b001);
      check(tok_busy, 1'b0);
      pulse(3'b010);
      wr(`UOTG_OFS_CTRL, 32'h00);
      settle;
      check(tok_busy, 1'b0);
      check(host_en, 1'b0);
      check(hlr_cnt - c, 32'h2);
   endtask : t_host

   task automatic t_resume;
      int c;
      wr(`UOTG_OFS_CTRL, 32'h0C);
      settle;
      check(res_drv, 1'b1);
      repeat (25 * MS) @(posedge clk_sys); // scaled host hold
      c = eop_cnt;
      wr(`UOTG_OFS_CTRL, 32'h08);
      repeat (40) @(posedge clk_sys);
      #1;
      check(eop_cnt - c, 32'd27);
      check(res_drv, 1'b0);
      wr(`UOTG_OFS_CTRL, 32'h00);
      wr(`UOTG_OFS_CTRL, 32'h04);
      repeat (10 * MS) @(posedge clk_sys); // scaled function hold
      c = eop_cnt;
      wr(`UOTG_OFS_CTRL, 32'h00);
      repeat (40) @(posedge clk_sys);
      #1;
      check(eop_cnt - c, 32'h0);
   endtask : t_resume

   // ---------------------------------------------------------------
   // sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset;
      t_id;
      t_vbus;
      t_timer;
      t_line;
      t_setup;
      t_host;
      t_resume;
      final_report;
   end

   initial begin
      repeat (10000) @(posedge clk_sys);
      err_count++;
      final_report;
   end
endmodule : test_usb_otg_status_control
